// ---- logic/dac_refresh_sequencer_ctrl.sv ----
`timescale 1ns/1ns

// Functional notes
// - Word shifted MSB first after select falls
// - Full word stores code, latches control bits
// - Word: code, index, zero, mode, clock, fill
// - Channel index is plain binary
// - Mode bit one selects immediate update
// - Clock bit one selects external clock
// - Mode bits ORed with their pins
// - Cycle all channels: load, then hold strobe
// - Internal clock: 20 us per channel
// - External clock: eight edges per channel
// - Select low suspends after current operation
// - Immediate update once select high, period done
// - Immediate update within two sequencer periods
// - Resume at interrupted channel after update
// - Burst stores words, outputs unchanged
// - After burst, resume at interrupted channel
// - External clock divided by four
// - Clock-select pin stops internal oscillator
// - Power-up loads default code everywhere
// - Reset pin repeats the default load
// - Reset sequence uses internal clock
// - Reset sequence ignores serial input
module dac_refresh_sequencer_ctrl
  import dac_seq_pkg::*;
(
  // Clock and power-on reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Serial port and control pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  input  wire logic        rst_pin_n,
  input  wire logic        instant_update_pin,
  input  wire logic        seq_clock_source_pin,
  input  wire logic        ext_seq_clock,
  // Converter and hold stages
  output logic [15:0]      dac_code,
  output logic [3:0]       hold_channel,
  output logic             hold_strobe,
  // Status
  output logic             reset_busy,
  output logic             instant_mode
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    pins_s             s1;
    pins_s             s2;
    pins_s             s3;
    logic [23:0]       shift;
    logic [4:0]        bit_cnt;
    logic [15:0][15:0] mem;
    logic              update_mode_bit;
    logic              clock_source_bit;
    logic              upd_pend;
    logic [3:0]        upd_ch;
    logic              upd_act;
    logic [3:0]        seq_ch;
    seq_phase_e        phase;
    logic [15:0]       dac;
    logic [3:0]        out_ch;
    logic              strobe;
    logic              rst_act;
    logic              imm;
    logic [6:0]        div;
    logic [1:0]        ecnt;
  } st_s;

  st_s st_reg;
  st_s st_next;

  logic        use_ext;
  logic        ext_rise;
  logic        sclk_rise;
  logic        tick;
  logic        word_done;
  logic [23:0] word;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next        = st_reg;
    st_next.strobe = 1'b0;
    // Pins pass two flops; third stage only feeds edge detection
    st_next.s1     = '{cs_n: cs_n, sclk: sclk, din: din, rst_pin_n: rst_pin_n,
                       instant: instant_update_pin, clk_src: seq_clock_source_pin,
                       ext_clk: ext_seq_clock};
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;

    // Pin ORed with serial bit; reset always runs on internal clock
    use_ext   = !st_reg.rst_act &&
                (st_reg.clock_source_bit || st_reg.s2.clk_src);
    ext_rise  = st_reg.s2.ext_clk && !st_reg.s3.ext_clk;
    sclk_rise = st_reg.s2.sclk && !st_reg.s3.sclk;
    word      = {st_reg.shift[22:0], st_reg.s2.din};
    word_done = 1'b0;
    tick      = 1'b0;

    // Sequencer period source
    if (use_ext) begin
      st_next.div = '0;
      if (ext_rise) begin
        st_next.ecnt = st_reg.ecnt + 2'h1;
        tick         = (st_reg.ecnt == EXT_DIV_LAST);
      end
    end else begin
      st_next.ecnt = '0;
      tick         = (st_reg.div == INT_TICK_LAST);
      st_next.div  = tick ? 7'h00 : st_reg.div + 7'h01;
    end

    // Serial shift; nothing is taken while reset runs
    if (st_reg.s2.cs_n || st_reg.rst_act) begin
      st_next.bit_cnt = '0;
    end else if (sclk_rise) begin
      st_next.shift = word;
      if (st_reg.bit_cnt == WORD_LAST_BIT) begin
        word_done       = 1'b1;
        st_next.bit_cnt = '0;
      end else begin
        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      end
    end

    // Store code and latch control bits at end of word
    if (word_done) begin
      st_next.mem[word[INDEX_MSB:INDEX_LSB]] = word[CODE_MSB:CODE_LSB];
      st_next.update_mode_bit  = word[UPDATE_MODE_POS];
      st_next.clock_source_bit = word[CLOCK_SRC_POS];
      if (word[UPDATE_MODE_POS] || st_reg.s2.instant) begin
        st_next.upd_pend = 1'b1;
        st_next.upd_ch   = word[INDEX_MSB:INDEX_LSB];
      end
    end
    st_next.imm = st_next.update_mode_bit || st_reg.s2.instant;

    // Sequencer: one period loads the converter, the next strobes hold
    if (tick) begin
      case (st_reg.phase)
        PH_LOAD: begin
          if (st_reg.upd_pend && st_reg.s2.cs_n && !st_reg.rst_act) begin
            st_next.dac      = st_reg.mem[st_reg.upd_ch];
            st_next.out_ch   = st_reg.upd_ch;
            st_next.upd_act  = 1'b1;
            st_next.upd_pend = 1'b0;
            st_next.phase    = PH_HOLD;
          end else if (st_reg.s2.cs_n || st_reg.rst_act) begin
            st_next.dac    = st_reg.mem[st_reg.seq_ch];
            st_next.out_ch = st_reg.seq_ch;
            st_next.phase  = PH_HOLD;
          end
          // Select low: no new channel, burst words wait in memory
        end
        PH_HOLD: begin
          // Operation in progress completes even with select low
          st_next.strobe = 1'b1;
          st_next.phase  = PH_LOAD;
          if (st_reg.upd_act) begin
            st_next.upd_act = 1'b0;
          end else begin
            st_next.seq_ch = st_reg.seq_ch + 4'h1;
            if (st_reg.rst_act && st_reg.seq_ch == LAST_CHANNEL) begin
              st_next.rst_act = 1'b0;
            end
          end
        end
        default: st_next.phase = PH_LOAD;
      endcase
    end

    // Reset pin restarts the default load; it cannot be interrupted
    if (!st_reg.s2.rst_pin_n) begin
      st_next.mem              = {16{DEFAULT_CODE}};
      st_next.rst_act          = 1'b1;
      st_next.seq_ch           = '0;
      st_next.phase            = PH_LOAD;
      st_next.upd_pend         = 1'b0;
      st_next.upd_act          = 1'b0;
      st_next.update_mode_bit  = 1'b0;
      st_next.clock_source_bit = 1'b0;
      st_next.bit_cnt          = '0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Power-on: every channel holds the default code and refresh starts
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg         <= '0;
      st_reg.s1      <= PINS_IDLE;
      st_reg.s2      <= PINS_IDLE;
      st_reg.s3      <= PINS_IDLE;
      st_reg.mem     <= {16{DEFAULT_CODE}};
      st_reg.rst_act <= 1'b1;
      st_reg.phase   <= PH_LOAD;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from flops
  assign dac_code     = st_reg.dac;
  assign hold_channel = st_reg.out_ch;
  assign hold_strobe  = st_reg.strobe;
  assign reset_busy   = st_reg.rst_act;
  assign instant_mode = st_reg.imm;

  // ************************************************************
  // Assertions
  // ************************************************************
  // One clock domain; internal state is watched directly
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  word_store_a: assert property (word_done && st_reg.s2.rst_pin_n |=>
    st_reg.mem[$past(word[INDEX_MSB:INDEX_LSB])] == $past(word[CODE_MSB:CODE_LSB]))
    else $error("word not stored at its channel");

  instant_pend_a: assert property (word_done && st_reg.s2.instant &&
    st_reg.s2.rst_pin_n |=>
    st_reg.upd_pend && st_reg.upd_ch == $past(word[INDEX_MSB:INDEX_LSB]))
    else $error("pin did not force immediate update");

  strobe_pulse_a: assert property (hold_strobe |=> !hold_strobe [*8])
    else $error("hold strobes too close together");

  suspend_hold_a: assert property (tick && st_reg.phase == PH_LOAD &&
    !st_reg.s2.cs_n && !st_reg.rst_act && st_reg.s2.rst_pin_n |=> st_reg.phase == PH_LOAD)
    else $error("channel started while select low");

  resume_ch_a: assert property (tick && st_reg.phase == PH_HOLD && st_reg.upd_act &&
    st_reg.s2.rst_pin_n |=> st_reg.seq_ch == $past(st_reg.seq_ch))
    else $error("sequence moved past interrupted channel");

  int_period_a: assert property (tick && !use_ext |-> $past(st_reg.div) == 7'(INT_TICK_CYC - 2))
    else $error("internal period wrong");

  ext_divide_a: assert property (tick && use_ext |-> st_reg.ecnt == EXT_DIV_LAST && ext_rise)
    else $error("external clock not divided by four");

  osc_stop_a: assert property (use_ext |=> st_reg.div == 7'h00)
    else $error("internal oscillator ran with external clock");

  reset_clk_a: assert property (st_reg.rst_act && st_reg.div == INT_TICK_LAST
    |-> tick)
    else $error("reset sequence left internal clock");

  reset_deaf_a: assert property (st_reg.rst_act |=> st_reg.bit_cnt == 5'h00)
    else $error("serial taken during reset");

  pin_reset_a: assert property (!st_reg.s2.rst_pin_n |=>
    st_reg.rst_act && st_reg.mem[st_reg.upd_ch] == DEFAULT_CODE && st_reg.seq_ch == 4'h0)
    else $error("reset pin did not reload defaults");

  // Latched control bits follow the word just completed
  mode_latch_a: assert property (word_done && st_reg.s2.rst_pin_n |=>
    st_reg.update_mode_bit == $past(word[UPDATE_MODE_POS]))
    else $error("update mode bit not latched");

  clock_latch_a: assert property (word_done && st_reg.s2.rst_pin_n |=>
    st_reg.clock_source_bit == $past(word[CLOCK_SRC_POS]))
    else $error("clock source bit not latched");

  // A high pin wins over a zero bit in the word
  mode_or_a: assert property (st_reg.s2.instant |=> instant_mode)
    else $error("instant pin not ORed into mode");

  // Converter must stay put while the host owns the port
  burst_quiet_a: assert property (!st_reg.s2.cs_n && !st_reg.rst_act |=>
    $stable(dac_code) && $stable(hold_channel))
    else $error("output changed during burst");

  // Pending update jumps the queue once select is back high
  instant_load_a: assert property (tick && st_reg.phase == PH_LOAD &&
    st_reg.upd_pend && st_reg.s2.cs_n && !st_reg.rst_act |=>
    dac_code == $past(st_reg.mem[st_reg.upd_ch]) && hold_channel == $past(st_reg.upd_ch))
    else $error("pending update not loaded");

  // Default load ends with the last channel's strobe
  reset_done_a: assert property (tick && st_reg.phase == PH_HOLD &&
    st_reg.rst_act && !st_reg.upd_act && st_reg.seq_ch == LAST_CHANNEL &&
    st_reg.s2.rst_pin_n |=> !reset_busy && hold_strobe)
    else $error("default load did not end on last channel");

  // ************************************************************
  // Cover points
  // ************************************************************
  instant_cov_c: cover property (tick && st_reg.phase == PH_HOLD && st_reg.upd_act);
  burst_cov_c: cover property (word_done && !st_next.imm ##[1:300] word_done);
  reset_cov_c: cover property (st_reg.rst_act ##1 !st_reg.rst_act);
  ext_cov_c:   cover property (tick && use_ext);

endmodule

// ---- logic/dac_seq_pkg.sv ----
package dac_seq_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS       = 100;    // ref_clk at 10 MHz
  localparam int CHANNEL_TIME_NS     = 20000;  // Internal clock, per channel
  localparam int SEQ_PERIODS_PER_CH  = 2;      // Load period, then hold period
  localparam int INT_TICK_CYC        =
    CHANNEL_TIME_NS / (CLK_PERIOD_NS * SEQ_PERIODS_PER_CH);
  localparam logic [6:0] INT_TICK_LAST = 7'(INT_TICK_CYC - 1);
  localparam logic [1:0] EXT_DIV_LAST  = 2'h3; // Four link edges per period

  // ************************************************************
  // Serial word layout
  // ************************************************************
  localparam logic [4:0] WORD_LAST_BIT = 5'h17;  // 24 bits per word
  localparam int CODE_MSB        = 23;
  localparam int CODE_LSB        = 8;
  localparam int INDEX_MSB       = 7;
  localparam int INDEX_LSB       = 4;
  localparam int UPDATE_MODE_POS = 2;
  localparam int CLOCK_SRC_POS   = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] DEFAULT_CODE = 16'h4f2c;
  localparam logic [3:0]  LAST_CHANNEL = 4'hf;

  typedef enum logic {PH_LOAD, PH_HOLD} seq_phase_e;

  // Pins from outside the ref_clk domain
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic rst_pin_n;
    logic instant;
    logic clk_src;
    logic ext_clk;
  } pins_s;

  localparam pins_s PINS_IDLE = '{cs_n: 1'b1, rst_pin_n: 1'b1, default: 1'b0};

endpackage

// ---- verification/host_serial_model.sv ----
`timescale 1ns/1ns
// ************************************************************
// Host side of the three-wire port
// ************************************************************
module host_serial_model (
  // Reference timing
  input  wire logic ref_clk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  // Select idle high, serial clock stands still between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Step just past a ref_clk edge so the device never races us
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  // One frame, top nbits of bits, most significant first
  // Levels held four cycles: the device needs three to see an edge
  task automatic send_frame(input logic [47:0] bits, input int nbits);
    int i;
    tick(1);
    cs_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      tick(1);
      din = bits[47-i];
      tick(4);
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(2);
    cs_n = 1'b1;
    din  = ~din; // Released line must not keep its last bit
  endtask
endmodule

// ---- verification/dac_refresh_sequencer_ctrl_tb.sv ----
`timescale 1ns/1ns
module dac_refresh_sequencer_ctrl_tb import dac_seq_pkg::*;;
  logic        ref_clk, resetn, cs_n, sclk, din, rst_pin_n, ext_run;
  logic        instant_update_pin, seq_clock_source_pin, ext_seq_clock;
  logic [15:0] dac_code;
  logic [3:0]  hold_channel;
  logic        hold_strobe, reset_busy, instant_mode;
  int          miscompares, cmp_count, cycles, g, gap;

  // ************************************************************
  // Clocks, device and host
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Link clock runs while ext_run is high, phase unrelated to ref_clk
  initial begin
    ext_seq_clock = 1'b0;
    #130;
    forever #400 ext_seq_clock = ext_run ? ~ext_seq_clock : ext_seq_clock;
  end
  dac_refresh_sequencer_ctrl dac_refresh_sequencer_ctrl_i (.ref_clk(ref_clk),
    .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din), .rst_pin_n(rst_pin_n),
    .instant_update_pin(instant_update_pin), .seq_clock_source_pin(seq_clock_source_pin),
    .ext_seq_clock(ext_seq_clock), .dac_code(dac_code), .hold_channel(hold_channel),
    .hold_strobe(hold_strobe), .reset_busy(reset_busy), .instant_mode(instant_mode));
  host_serial_model host_serial_model_i (.ref_clk(ref_clk), .cs_n(cs_n),
    .sclk(sclk), .din(din));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  function automatic logic [23:0] word(input logic [15:0] c, input logic [3:0] ch,
                                       input logic m, input logic s);
    return {c, ch, 1'b0, m, s, 1'b0};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe of channel ch, or of any channel when ch[4]; cyc == lim if none
  task automatic wait_strobe(input logic [4:0] ch, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(negedge ref_clk);
      cyc++;
    end while (!(hold_strobe === 1'b1 && (ch[4] || hold_channel === ch[3:0]))
               && cyc < lim);
  endtask
  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Word sent during the default load must be dropped
  task automatic t_reset;
    host_serial_model_i.send_frame({word(16'h1111, 4'hf, 1'b1, 1'b0), 24'h0}, 24);
    wait_strobe(5'h0f, 3300, g);
    check(16'(g < 3300), 16'h1);
    check(dac_code, DEFAULT_CODE);
    tick(3);
    check(16'(reset_busy), 16'h0);
    $display("Test reset done");
  endtask
  // Two stored words, refreshed later in sequence order
  task automatic t_burst;
    host_serial_model_i.send_frame({word(16'h1357, 4'h2, 1'b0, 1'b0),
                                    word(16'h2468, 4'h5, 1'b0, 1'b0)}, 48);
    check(16'(instant_mode), 16'h0);
    wait_strobe(5'h02, 3400, g);
    check(dac_code, 16'h1357);
    wait_strobe(5'h05, 800, g);
    check(dac_code, 16'h2468);
    check(16'(g), 16'h0258);
    // Host keeps off the port for ten channels after the burst, up to channel 15's strobe
    wait_strobe(5'h0f, 2200, g);
    check(16'(g), 16'h07d0);
    $display("Test burst done");
  endtask
  // Update within two periods, by word bit or by pin
  task automatic t_immediate(input logic [3:0] ch, input logic [15:0] c,
                             input logic pin);
    tick(1);
    instant_update_pin = pin;
    host_serial_model_i.send_frame({word(c, ch, ~pin, 1'b0), 24'h0}, 24);
    wait_strobe({1'b0, ch}, 210, g);
    check(16'(g < 210), 16'h1);
    check(dac_code, c);
    check(16'(instant_mode), 16'h1);
    tick(1);
    instant_update_pin = 1'b0;
    $display("Test immediate done");
  endtask
  // External clock: eight link cycles per channel, then stopped
  task automatic t_ext_clock;
    host_serial_model_i.send_frame({word(16'h00aa, 4'h0, 1'b0, 1'b1), 24'h0}, 24);
    wait_strobe(5'h10, 300, g);
    wait_strobe(5'h10, 300, g);
    wait_strobe(5'h10, 300, gap);
    check(16'(gap >= 62 && gap <= 66), 16'h1);
    tick(1);
    seq_clock_source_pin = 1'b1;
    ext_run = 1'b0;
    tick(80);
    wait_strobe(5'h10, 300, g);
    check(16'(g), 16'h012c);
    $display("Test external clock done");
  endtask
  // Reset pin reloads on internal clock though the link clock is stopped
  task automatic t_reset_pin;
    tick(1);
    rst_pin_n = 1'b0;
    tick(5);
    check(16'(reset_busy), 16'h1);
    rst_pin_n = 1'b1;
    wait_strobe(5'h00, 300, g);
    check(16'(g < 300), 16'h1);
    check(dac_code, DEFAULT_CODE);
    $display("Test reset pin done");
  endtask

  // ************************************************************
  // Main sequence and hang guard
  // ************************************************************
  initial begin
    resetn = 1'b0;
    rst_pin_n = 1'b1;
    instant_update_pin = 1'b0;
    seq_clock_source_pin = 1'b0;
    ext_run = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    tick(8);
    resetn = 1'b1;
    t_reset;
    t_burst;
    t_immediate(4'hc, 16'hbeef, 1'b0);
    t_immediate(4'h7, 16'h0f0f, 1'b1);
    t_ext_clock;
    t_reset_pin;
    report_and_stop;
  end
  // Whole run needs about 8600 cycles
  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == 25000) begin
        miscompares++;
        report_and_stop;
      end
    end
  end
endmodule
